// *** sim/ntb_address_translation_router_test.sv ***
/* Self-checking bench for the bridge router with a reference model.
   Assumes the far-side model file and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ntb_address_translation_router_test;
    import ntb_router_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, valid, side, dfp, tx_valid, tx_side, cfg_local, cfg_side;
    logic reg_wr = 1'b0, reg_rd = 1'b0, e_fwd, e_cfg, e_side;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, data, tx_data, e_data;
    logic [31:0] bar [2][4] = '{default: '0}, stp [2][4] = '{default: '0};
    logic [31:0] xl [2][4] = '{default: '0};
    logic [63:0] addr, tx_addr, e_addr;
    logic [64:0] hx;
    logic [15:0] id, tx_id, e_id;
    pkt_kind_t kind, tx_kind, e_kind;
    int n_fail = 0, samples_checked = 0;
    int cnt [4] = '{default: 0};
    logic [31:0] st, e_cfg_data = 32'h0;

    always #50 clk = ~clk;

    ntb_root_complex_model u_ntb_root_complex_model (.clk_i(clk), .valid_o(valid),
        .side_o(side), .dfp_o(dfp), .kind_o(kind), .addr_o(addr), .id_o(id), .data_o(data));
    ntb_address_translation_router u_ntb_address_translation_router (.clk_i(clk),
        .rstn_i(rstn), .rx_valid_i(valid), .rx_side_i(side),
        .rx_from_downward_facing_port_i(dfp), .rx_kind_i(kind), .rx_addr_i(addr),
        .rx_req_id_i(id), .rx_data_i(data), .tx_valid_o(tx_valid), .tx_side_o(tx_side),
        .tx_kind_o(tx_kind), .tx_addr_o(tx_addr), .tx_req_id_o(tx_id), .tx_data_o(tx_data),
        .cfg_local_o(cfg_local), .cfg_side_o(cfg_side), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Register port master: one strobe cycle, data read in the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, e);
    endtask

    // Program one window and keep the model's copy in step
    task automatic win(input int s, w, input logic [31:0] st, b, x);
        logic [7:0] a;
        a = SIDE_STRIDE * 8'(s) + WIN_STRIDE * 8'(w);
        stp[s][w] = st;
        bar[s][w] = b;
        xl[s][w] = x;
        wr(a + OFF_SETUP, st);
        wr(a + OFF_BAR_LO, b);
        wr(a + OFF_XLAT_LO, x);
        rd(a + OFF_SETUP, st);
    endtask

    // Reference window search; lowest matching window wins
    function automatic logic [64:0] xlate(input logic s, input logic [63:0] a, input logic io);
        logic [63:0] m, b, x;
        for (int w = 0; w < NUM_WIN; w++) begin
            m = ~64'h0 << stp[s][w][13:8];
            b = {32'h0, bar[s][w]};
            x = {32'h0, xl[s][w]};
            if (w % 2 == 0 && stp[s][w][2]) begin
                b = {bar[s][w + 1], bar[s][w]};
                x = {xl[s][w + 1], xl[s][w]};
            end
            if (w % 2 == 1 && stp[s][w - 1][2])
                continue;
            if (stp[s][w][0] && stp[s][w][1] == io && (a & m) == (b & m))
                return {1'b1, (x & m) | (a & ~m)};
        end
        return 65'h0;
    endfunction

    // Predict at the taking edge, compare once the registered answer settles
    always begin
        @(posedge clk);
        {e_fwd, e_cfg} = 2'b00;
        if (rstn && valid) begin
            hx = xlate(side, addr, kind inside {PKT_IO_RD, PKT_IO_WR});
            e_cfg = kind inside {PKT_CFG_RD, PKT_CFG_WR} && !dfp;
            e_fwd = kind == PKT_CPL || (kind <= PKT_IO_WR && hx[64]);
            e_addr = (kind == PKT_CPL) ? addr : hx[63:0];
            e_side = !side;
            e_kind = kind;
            {e_id, e_data} = {id, data};
            // Software-visible counts and the last inner config word
            cnt[0] += int'(e_fwd);
            cnt[1] += int'(kind <= PKT_IO_WR && !hx[64]);
            cnt[1] += int'(kind inside {PKT_CFG_RD, PKT_CFG_WR} && dfp);
            cnt[2] += int'(kind == PKT_MSG);
            cnt[3] += int'(e_cfg);
            if (e_cfg && !side && kind == PKT_CFG_WR)
                e_cfg_data = data;
        end
        @(negedge clk);
        check(tx_valid, e_fwd);
        check(cfg_local, e_cfg);
        if (e_cfg)
            check(cfg_side, !e_side);
        if (e_fwd) begin
            check(tx_addr, e_addr);
            check(tx_side, e_side);
            check(tx_kind, e_kind);
            check({tx_id, tx_data}, {e_id, e_data});
        end
    end

    // Random packets near, inside and far from the programmed windows, an idle slot before about one in four
    task automatic traffic(input int n);
        int s, w, p;
        logic [63:0] a;
        for (int j = 0; j < n; j++) begin
            s = $urandom_range(1);
            w = $urandom_range(3);
            p = $urandom_range(7);
            a = {32'h0, bar[s][w]} + 64'($urandom_range(4095));
            if (p == 0) a = {$urandom, $urandom};
            if (p == 1) a = {32'h0, bar[s][w]} - 64'h1;
            if (p > 5) a[63:32] = bar[s][w | 1];
            if ($urandom_range(3) == 0) u_ntb_root_complex_model.push('0);
            u_ntb_root_complex_model.push({1'b1, 1'(s), 1'($urandom_range(1)),
                pkt_kind_t'($urandom_range(7)), a, 16'($urandom), $urandom});
        end
        while (u_ntb_root_complex_model.q.size() > 0)
            @(posedge clk);
        repeat (3) @(posedge clk);
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #3000000;
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h96c59f25));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(OFF_SETUP, SETUP_RESET);
        rd(SIDE_STRIDE + 8'h30 + OFF_SETUP, SETUP_RESET);
        wr(8'hf0, 32'hffff_ffff);
        rd(8'hf0, 32'h0);
        // Mixed layout on the inner side, four 32-bit on the outer side
        win(0, 0, 32'h0000_0c01, 32'h1000_0000, 32'h8000_0000);
        win(0, 1, 32'h0000_0c03, 32'h0000_2000, 32'h0000_5000);
        win(0, 2, 32'h0000_1405, 32'h0010_0000, 32'h0020_0000);
        win(0, 3, 32'h0, 32'h0000_0001, 32'h0000_0002);
        win(1, 0, 32'h0000_1001, 32'h8000_0000, 32'h3000_0000);
        win(1, 1, 32'h0000_0c01, 32'h8000_0000, 32'h4000_0000);
        win(1, 2, 32'h0000_0c03, 32'h0000_7000, 32'h0000_9000);
        win(1, 3, 32'h0000_0e01, 32'h0400_0000, 32'h0500_0000);
        traffic(400);
        // Two 64-bit windows on the inner side
        win(0, 0, 32'h0000_1405, 32'h2000_0000, 32'h6000_0000);
        win(0, 1, 32'h0, 32'h0000_0003, 32'h0000_0004);
        traffic(400);
        // Counters saturate at 255
        for (int i = 0; i < 4; i++)
            st[i * 8 +: 8] = (cnt[i] > 255) ? 8'hff : 8'(cnt[i]);
        rd(OFF_STATUS, st);
        rd(OFF_CFG_DATA, e_cfg_data);
        end_of_test();
    end
endmodule
`default_nettype wire

// *** sim/ntb_root_complex_model.sv ***
/* Far-side packet source standing for the root complexes of both sides.
   Assumes one packet per edge at most and a receiver that never stalls. */
`timescale 1ns/1ps
`default_nettype none
module ntb_root_complex_model (
    input wire logic clk_i,
    output logic valid_o,
    output logic side_o,
    output logic dfp_o,
    output ntb_router_pkg::pkt_kind_t kind_o,
    output logic [63:0] addr_o,
    output logic [15:0] id_o,
    output logic [31:0] data_o
);
    import ntb_router_pkg::*;
    typedef struct packed {
        logic v;
        logic s;
        logic d;
        pkt_kind_t k;
        logic [63:0] a;
        logic [15:0] i;
        logic [31:0] w;
    } rc_pkt_t;
    rc_pkt_t q[$];
    rc_pkt_t c;

    // Queue a packet, or an idle slot when v is low
    task automatic push(input rc_pkt_t p);
        q.push_back(p);
    endtask

    initial begin
        valid_o = 1'b0;
        kind_o = PKT_MEM_RD;
        {side_o, dfp_o, addr_o, id_o, data_o} = '0;
    end

    // Idle lines toggle so a stale field never looks like a packet
    always @(posedge clk_i) begin
        c = (q.size() > 0) ? q.pop_front() : '0;
        valid_o <= c.v;
        if (c.v) begin
            {side_o, dfp_o, addr_o, id_o, data_o} <= {c.s, c.d, c.a, c.i, c.w};
            kind_o <= c.k;
        end else begin
            {side_o, dfp_o, addr_o, id_o, data_o} <= ~{side_o, dfp_o, addr_o, id_o, data_o};
            kind_o <= pkt_kind_t'(~kind_o);
        end
    end
endmodule
`default_nettype wire

// *** sim/ntb_router_assertions.sv ***
/* Port checker for the bridge router: packet kinds, sides and offsets.
   Assumes binding onto the router top module, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module ntb_router_assertions (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic rx_valid_i,
    input wire logic rx_side_i,
    input wire logic rx_from_downward_facing_port_i,
    input wire ntb_router_pkg::pkt_kind_t rx_kind_i,
    input wire logic [ntb_router_pkg::ADDR_W-1:0] rx_addr_i,
    input wire logic tx_valid_o,
    input wire logic tx_side_o,
    input wire ntb_router_pkg::pkt_kind_t tx_kind_o,
    input wire logic [ntb_router_pkg::ADDR_W-1:0] tx_addr_o,
    input wire logic cfg_local_o,
    input wire logic cfg_side_o
);
    import ntb_router_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Arrivals and the silent answer
    sequence s_cfg_in;
        rx_valid_i && (rx_kind_i == PKT_CFG_RD || rx_kind_i == PKT_CFG_WR);
    endsequence
    sequence s_quiet;
        !tx_valid_o && !cfg_local_o;
    endsequence
    property p_cfg_local;
        s_cfg_in ##0 !rx_from_downward_facing_port_i |=>
            cfg_local_o && !tx_valid_o && cfg_side_o == $past(rx_side_i);
    endproperty
    a_cfg_local: assert property (p_cfg_local) else $error("config not local");
    property p_cfg_dfp;
        s_cfg_in ##0 rx_from_downward_facing_port_i |=> s_quiet;
    endproperty
    a_cfg_dfp: assert property (p_cfg_dfp) else $error("config not dropped");
    property p_msg_drop;
        rx_valid_i && rx_kind_i == PKT_MSG |=> s_quiet;
    endproperty
    a_msg_drop: assert property (p_msg_drop) else $error("message answered");
    property p_no_cross;
        tx_valid_o |-> !(tx_kind_o inside {PKT_CFG_RD, PKT_CFG_WR, PKT_MSG});
    endproperty
    a_no_cross: assert property (p_no_cross) else $error("bad kind forwarded");
    property p_cpl_fwd;
        rx_valid_i && rx_kind_i == PKT_CPL ##0 !rx_from_downward_facing_port_i |=>
            tx_valid_o && tx_kind_o == PKT_CPL && tx_addr_o == $past(rx_addr_i);
    endproperty
    a_cpl_fwd: assert property (p_cpl_fwd) else $error("completion lost");
    property p_side_flip;
        tx_valid_o |-> $past(rx_valid_i) && tx_side_o != $past(rx_side_i);
    endproperty
    a_side_flip: assert property (p_side_flip) else $error("wrong side");
    property p_offset;
        tx_valid_o && tx_kind_o != PKT_CPL |->
            ((tx_addr_o ^ $past(rx_addr_i)) & 64'hfff) == 64'h0;
    endproperty
    a_offset: assert property (p_offset) else $error("offset altered");
    property p_fwd_kind;
        tx_valid_o |-> tx_kind_o == $past(rx_kind_i);
    endproperty
    a_fwd_kind: assert property (p_fwd_kind) else $error("kind changed");
    property p_idle;
        !rx_valid_i |=> s_quiet;
    endproperty
    a_idle: assert property (p_idle) else $error("output without packet");
endmodule

bind ntb_address_translation_router ntb_router_assertions u_ntb_router_assertions (
    .clk_i, .rstn_i, .rx_valid_i, .rx_side_i, .rx_from_downward_facing_port_i,
    .rx_kind_i, .rx_addr_i, .tx_valid_o, .tx_side_o, .tx_kind_o, .tx_addr_o,
    .cfg_local_o, .cfg_side_o
);
`default_nettype wire

// *** verilog/ntb_address_translation_router.sv ***
/*
 * Routing and address translation core of a non-transparent bridge
 * joining an inner side endpoint and an outer side endpoint.
 * Assumes packets arrive one header per cycle with a valid strobe, the
 * receiver of forwarded packets never stalls, and registers are written
 * by local software over a plain strobe port.
 */
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Three ports: upstream, downward facing, bridge
// - Outer link presents an endpoint, not bridge
// - Configs from downward facing port silently dropped
// - Memory and IO requests routed by address
// - Completions routed by ID across bridge (here every completion is forwarded, ID not examined)
// - Configs and messages never cross bridge
// - Messages discarded with no response
// - Configs handled by the receiving endpoint
// - Four of five BARs map 32-bit windows
// - Odd/even BAR pair forms 64-bit window
// - Four 32, two 64, or mixed
// - Setup register picks memory/IO and size
// - Translated-base register per window
// - Base bits set by window size
// - Address and type checked against four windows
// - Hit replaces base with translated base
// - Miss drops the request
// - Same translation in both directions
// - Back-to-back requests translated again
module ntb_address_translation_router (
    input wire logic clk_i,
    input wire logic rstn_i,
    // Packet arriving at one endpoint of the bridge
    input wire logic rx_valid_i,
    input wire logic rx_side_i,
    input wire logic rx_from_downward_facing_port_i,
    input wire ntb_router_pkg::pkt_kind_t rx_kind_i,
    input wire logic [ntb_router_pkg::ADDR_W-1:0] rx_addr_i,
    input wire logic [15:0] rx_req_id_i,
    input wire logic [31:0] rx_data_i,
    // Forwarded packet leaving the opposite endpoint
    output logic tx_valid_o,
    output logic tx_side_o,
    output ntb_router_pkg::pkt_kind_t tx_kind_o,
    output logic [ntb_router_pkg::ADDR_W-1:0] tx_addr_o,
    output logic [15:0] tx_req_id_o,
    output logic [31:0] tx_data_o,
    // Local configuration request completed by the receiving endpoint
    output logic cfg_local_o,
    output logic cfg_side_o,
    // Register port
    input wire logic [ntb_router_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import ntb_router_pkg::*;

    // Per side, per window register state
    logic [31:0] bar_lo [NUM_SIDE][NUM_WIN];
    logic [31:0] bar_hi [NUM_SIDE][NUM_WIN];
    logic [31:0] setup [NUM_SIDE][NUM_WIN];
    logic [31:0] xlat_lo [NUM_SIDE][NUM_WIN];
    logic [31:0] xlat_hi [NUM_SIDE][NUM_WIN];
    logic [31:0] cfg_data [NUM_SIDE];

    // Event counters shown to software
    logic [7:0] fwd_count;
    logic [7:0] drop_count;
    logic [7:0] msg_count;
    logic [7:0] cfg_count;

    // Per window decode results for the arriving side
    logic [NUM_WIN-1:0] win_hit;
    logic [ADDR_W-1:0] win_addr [NUM_WIN];
    logic [ADDR_W-1:0] win_base [NUM_WIN];
    logic [ADDR_W-1:0] win_xlat [NUM_WIN];
    logic [31:0] win_setup [NUM_WIN];
    logic rx_is_io;
    logic rx_is_req;

    assign rx_is_io = (rx_kind_i == PKT_IO_RD) || (rx_kind_i == PKT_IO_WR);
    assign rx_is_req = (rx_kind_i == PKT_MEM_RD) || (rx_kind_i == PKT_MEM_WR) || rx_is_io;

    // One matcher per window on whichever endpoint received the packet
    genvar w;
    generate
        for (w = 0; w < NUM_WIN; w = w + 1) begin : g_win
            // Other half of the pair; never indexes outside the four windows
            localparam int PAIR = w ^ 1;
            // An even BAR flagged 64-bit takes its upper half from the odd BAR
            always_comb begin
                win_setup[w] = setup[rx_side_i][w];
                win_base[w] = {bar_hi[rx_side_i][w], bar_lo[rx_side_i][w]};
                win_xlat[w] = {xlat_hi[rx_side_i][w], xlat_lo[rx_side_i][w]};
                if ((w % 2) == 0) begin
                    if (setup[rx_side_i][w][SETUP_W64_BIT]) begin
                        win_base[w] = {bar_lo[rx_side_i][PAIR], bar_lo[rx_side_i][w]};
                        win_xlat[w] = {xlat_lo[rx_side_i][PAIR], xlat_lo[rx_side_i][w]};
                    end
                end else begin
                    // Odd half of a pair is consumed by its partner
                    if (setup[rx_side_i][PAIR][SETUP_W64_BIT]) begin
                        win_setup[w] = SETUP_RESET;
                    end
                end
            end
            ntb_window_match u_match (
                .addr_i(rx_addr_i),
                .is_io_i(rx_is_io),
                .base_i(win_base[w]),
                .xlat_i(win_xlat[w]),
                .setup_i(win_setup[w]),
                .hit_o(win_hit[w]),
                .addr_xlat_o(win_addr[w])
            );
        end
    endgenerate

    // Lowest numbered hitting window wins; overlap is a software error
    logic any_hit;
    logic [ADDR_W-1:0] hit_addr;
    always_comb begin
        any_hit = 1'b0;
        hit_addr = rx_addr_i;
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (win_hit[i]) begin
                any_hit = 1'b1;
                hit_addr = win_addr[i];
            end
        end
    end

    // Routing decision per packet kind; same path both ways
    logic next_fwd;
    logic next_cfg;
    logic next_drop;
    logic next_msg;
    always_comb begin
        next_fwd = 1'b0;
        next_cfg = 1'b0;
        next_drop = 1'b0;
        next_msg = 1'b0;
        if (rx_valid_i) begin
            case (rx_kind_i)
                PKT_MEM_RD, PKT_MEM_WR, PKT_IO_RD, PKT_IO_WR: begin
                    next_fwd = any_hit;
                    next_drop = !any_hit;
                end
                PKT_CPL: begin
                    next_fwd = 1'b1;
                end
                PKT_CFG_RD, PKT_CFG_WR: begin
                    // Downward facing port configs go nowhere
                    next_cfg = !rx_from_downward_facing_port_i;
                    next_drop = rx_from_downward_facing_port_i;
                end
                default: begin
                    next_msg = 1'b1;
                end
            endcase
        end
    end

    // Forwarded packet leaves the opposite endpoint one cycle later
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_valid_o <= 1'b0;
            tx_side_o <= SIDE_INNER;
            tx_kind_o <= PKT_MSG;
            tx_addr_o <= 64'h0;
            tx_req_id_o <= 16'h0;
            tx_data_o <= 32'h0;
        end else begin
            tx_valid_o <= next_fwd;
            if (next_fwd) begin
                tx_side_o <= !rx_side_i;
                tx_kind_o <= rx_kind_i;
                tx_addr_o <= rx_rs_is_cpl(rx_kind_i) ? rx_addr_i : hit_addr;
                tx_req_id_o <= rx_req_id_i;
                tx_data_o <= rx_data_i;
            end
        end
    end

    function automatic logic rx_rs_is_cpl(input pkt_kind_t k);
        rx_rs_is_cpl = (k == PKT_CPL);
    endfunction

    // Local config: receiving endpoint is the target, outer side included
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg_local_o <= 1'b0;
            cfg_side_o <= SIDE_INNER;
            for (int s = 0; s < NUM_SIDE; s++) begin
                cfg_data[s] <= 32'h0;
            end
        end else begin
            cfg_local_o <= next_cfg;
            if (next_cfg) begin
                cfg_side_o <= rx_side_i;
                if (rx_kind_i == PKT_CFG_WR) begin
                    cfg_data[rx_side_i] <= rx_data_i;
                end
            end
        end
    end

    // Counters saturate so software can see any activity at all
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fwd_count <= 8'h0;
            drop_count <= 8'h0;
            msg_count <= 8'h0;
            cfg_count <= 8'h0;
        end else begin
            if (next_fwd && fwd_count != 8'hff) fwd_count <= fwd_count + 8'h1;
            if (next_drop && drop_count != 8'hff) drop_count <= drop_count + 8'h1;
            if (next_msg && msg_count != 8'hff) msg_count <= msg_count + 8'h1;
            if (next_cfg && cfg_count != 8'hff) cfg_count <= cfg_count + 8'h1;
        end
    end

    // Register address split: side, window, field
    logic reg_side;
    logic [1:0] reg_win;
    logic [7:0] reg_field;
    logic reg_in_win;
    logic reg_is_xhi;
    assign reg_side = reg_addr_i[6];
    assign reg_win = reg_addr_i[5:4];
    assign reg_field = {4'h0, reg_addr_i[3:0]};
    assign reg_in_win = (reg_addr_i[7] == 1'b0);
    assign reg_is_xhi = (reg_addr_i[7:6] == 2'b10) && (reg_addr_i[1:0] == 2'b00);

    // Window registers: BAR, setup, translated base
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int s = 0; s < NUM_SIDE; s++) begin
                for (int i = 0; i < NUM_WIN; i++) begin
                    bar_lo[s][i] <= 32'h0;
                    bar_hi[s][i] <= 32'h0;
                    setup[s][i] <= SETUP_RESET;
                    xlat_lo[s][i] <= 32'h0;
                    xlat_hi[s][i] <= 32'h0;
                end
            end
        end else if (reg_wr_i) begin
            if (reg_in_win && reg_field == OFF_BAR_LO) begin
                bar_lo[reg_side][reg_win] <= reg_wdata_i;
            end else if (reg_in_win && reg_field == OFF_BAR_HI) begin
                bar_hi[reg_side][reg_win] <= reg_wdata_i;
            end else if (reg_in_win && reg_field == OFF_SETUP) begin
                setup[reg_side][reg_win] <= reg_wdata_i;
            end else if (reg_in_win && reg_field == OFF_XLAT_LO) begin
                xlat_lo[reg_side][reg_win] <= reg_wdata_i;
            end else if (reg_is_xhi) begin
                xlat_hi[reg_addr_i[5]][reg_addr_i[4:3]] <= reg_wdata_i;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            if (reg_in_win && reg_field == OFF_BAR_LO) begin
                reg_rdata_o <= bar_lo[reg_side][reg_win];
            end else if (reg_in_win && reg_field == OFF_BAR_HI) begin
                reg_rdata_o <= bar_hi[reg_side][reg_win];
            end else if (reg_in_win && reg_field == OFF_SETUP) begin
                reg_rdata_o <= setup[reg_side][reg_win];
            end else if (reg_in_win && reg_field == OFF_XLAT_LO) begin
                reg_rdata_o <= xlat_lo[reg_side][reg_win];
            end else if (reg_is_xhi) begin
                reg_rdata_o <= xlat_hi[reg_addr_i[5]][reg_addr_i[4:3]];
            end else if (reg_addr_i == OFF_STATUS) begin
                reg_rdata_o <= {cfg_count, msg_count, drop_count, fwd_count};
            end else if (reg_addr_i == OFF_CFG_DATA) begin
                reg_rdata_o <= cfg_data[SIDE_INNER];
            end else begin
                reg_rdata_o <= 32'h0;
            end
        end
    end

    // Only the bridge path lives here; the upstream port sits above
endmodule
`default_nettype wire

// *** verilog/ntb_router_pkg.sv ***
/*
 * Shared constants for the bridge router: packet kinds, register map,
 * window setup fields and reset values.
 * Assumes one clock domain and a plain register port on the main module.
 */
package ntb_router_pkg;
    typedef enum logic [2:0] {
        PKT_MEM_RD, PKT_MEM_WR, PKT_IO_RD, PKT_IO_WR,
        PKT_CPL, PKT_CFG_RD, PKT_CFG_WR, PKT_MSG
    } pkt_kind_t;

    localparam int ADDR_W = 64;
    localparam int NUM_WIN = 4;
    localparam int NUM_SIDE = 2;
    localparam int REG_AW = 8;

    // Side codes: 0 inner side endpoint, 1 outer side endpoint
    localparam logic SIDE_INNER = 1'b0;
    localparam logic SIDE_OUTER = 1'b1;

    // Register map: per side block of 0x40, per window 0x10
    localparam logic [7:0] SIDE_STRIDE = 8'h40;
    localparam logic [7:0] WIN_STRIDE = 8'h10;
    localparam logic [7:0] OFF_BAR_LO = 8'h00;
    localparam logic [7:0] OFF_BAR_HI = 8'h04;
    localparam logic [7:0] OFF_SETUP = 8'h08;
    localparam logic [7:0] OFF_XLAT_LO = 8'h0c;
    localparam logic [7:0] OFF_XLAT_HI_BASE = 8'h80;
    localparam logic [7:0] OFF_STATUS = 8'hc0;
    localparam logic [7:0] OFF_CFG_DATA = 8'hc4;

    // Setup register fields
    localparam int SETUP_EN_BIT = 0;
    localparam int SETUP_IO_BIT = 1;
    localparam int SETUP_W64_BIT = 2;
    localparam int SETUP_SIZE_LSB = 8;
    localparam int SETUP_SIZE_W = 6;
    localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
    localparam logic [5:0] MIN_SIZE_LOG2 = 6'h0c;
endpackage

// *** verilog/ntb_window_match.sv ***
/*
 * One translating window: compares a request address and kind against a
 * base and size, and builds the translated address.
 * Assumes size and base come from registers owned by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module ntb_window_match (
    input wire logic [ntb_router_pkg::ADDR_W-1:0] addr_i,
    input wire logic is_io_i,
    input wire logic [ntb_router_pkg::ADDR_W-1:0] base_i,
    input wire logic [ntb_router_pkg::ADDR_W-1:0] xlat_i,
    input wire logic [31:0] setup_i,
    output logic hit_o,
    output logic [ntb_router_pkg::ADDR_W-1:0] addr_xlat_o
);
    import ntb_router_pkg::*;

    logic [5:0] size_log2;
    logic [ADDR_W-1:0] off_mask;
    logic in_range;

    // Size field sets which upper bits form the base
    always_comb begin
        size_log2 = setup_i[SETUP_SIZE_LSB +: SETUP_SIZE_W];
        if (size_log2 < MIN_SIZE_LOG2) begin
            size_log2 = MIN_SIZE_LOG2;
        end
        off_mask = (64'h1 << size_log2) - 64'h1;
        // A 32-bit window ignores anything above 4 GiB; top bits must be zero
        if (setup_i[SETUP_W64_BIT]) begin
            in_range = ((addr_i & ~off_mask) == (base_i & ~off_mask));
        end else begin
            in_range = (addr_i[63:32] == 32'h0000_0000) &&
                ((addr_i[31:0] & ~off_mask[31:0]) == (base_i[31:0] & ~off_mask[31:0]));
        end
    end

    // Type and address both must agree
    assign hit_o = setup_i[SETUP_EN_BIT] && (setup_i[SETUP_IO_BIT] == is_io_i) && in_range;
    // Offset passes, base bits replaced
    assign addr_xlat_o = (addr_i & off_mask) | (xlat_i & ~off_mask);
endmodule
`default_nettype wire
